// ==== core/fpc_consts.svh ====
/*
  Flash page program controller: field positions, key values,
  address split and range limits.
  Assumes inclusion by the controller and key-detector modules.
*/
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH
`define FPC_KEY_MSB 7
`define FPC_KEY_LSB 4
`define FPC_MAP_BIT 3
`define FPC_SEL_MSB 2
`define FPC_SEL_LSB 1
`define FPC_BUSY_BIT 0
`define FPC_KEY_ARM 4'h5
`define FPC_KEY_FIRE 4'hA
`define FPC_HALF_BIT 6
`define FPC_PAGE_LSB 7
`define FPC_PAGE_MSB 15
`define FPC_SIG_TOP 16'h01FF
`define FPC_FUSE_TOP 16'h007F
`endif

// ==== core/fpc_flash_ctrl.sv ====
/*
  Flash page program controller: control register, space mapping,
  buffer loading, key launch, erase/program sequencing, status.
  Assumes a flash array that answers each request with arr_ack,
  programs only zero bits on a program request, and returns read
  data for arr_rd itself. All inputs are synchronous to clock.
*/
// Contract
// - Code area is read-only via code reads; no write path unless mapped.
// - Mapped data writes go to the write-only buffer, else to data RAM.
// - Address bits 6..0 select the byte, bits 15..7 the page.
// - Buffer mapping overrides the external-RAM select for data writes.
// - Space select 00 code, 01 signature, 10 fuses, 11 reserved.
// - Programming launches only after key 5 then key A.
// - First key does nothing; second copies buffer; reserved select ignored.
// - Any other instruction between the two keys aborts the launch.
// - Busy flag is set while programming and cleared by hardware.
// - Brown-out during programming sets the nonvolatile error flag.
// - Buffer holds 64 bytes, one half of a 128-byte page.
// - Buffer takes 1 to 64 bytes; a loaded byte is not reloaded.
// - Buffer and loaded markers clear after every erase or write.
// - Without auto-erase, unloaded bytes untouched; loaded ones program zeros.
// - Auto-erase wipes the whole page first; unloaded bytes end as FFH.
// - Internal launch idles the core; external launch lets software poll.
// - The page of the last buffer write is the programming target.
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_flash_ctrl #(
  parameter int BUF_DEPTH = 64,
  parameter int IDX_W = 6
) (
  input wire logic clock, // Core clock, 125 MHz
  input wire logic rst_n, // Synchronous reset
  input wire logic instr_done, // Instruction retired
  input wire logic ctrl_wr, // Control register write
  input wire logic [7:0] ctrl_wdata, // Control write data
  output logic [7:0] ctrl_rdata, // Control readback
  input wire logic xdata_wr, // External-data write
  input wire logic [15:0] xdata_addr, // Pointer address
  input wire logic [7:0] xdata_wdata, // Write data
  input wire logic ext_ram_select, // Aux external-RAM bit
  output logic ram_wr, // Data memory write
  output logic ram_ext, // Write goes off-chip
  output logic [15:0] ram_addr, // Data memory address
  output logic [7:0] ram_wdata, // Data memory data
  input wire logic code_rd, // Code-read request
  input wire logic [15:0] code_addr, // Code-read address
  output logic arr_rd, // Array read strobe
  output fpc_pkg::fpc_space_t arr_rd_space, // Space read
  output logic [15:0] arr_rd_addr, // Address read
  input wire logic auto_page_erase, // Auto-erase enable
  input wire logic exec_internal, // Core runs from on-chip
  input wire logic brown_out, // Supply fault
  input wire logic nv_error_clr, // Clear error flag
  output logic program_in_progress, // Busy flag
  output logic cpu_idle, // Hold core idle
  output logic nv_error, // Programming error flag
  output logic arr_req, // Array request
  output logic arr_erase, // Request is page erase
  output fpc_pkg::fpc_space_t arr_space, // Target space
  output logic [15:0] arr_addr, // Target address
  output logic [7:0] arr_wdata, // Program data
  input wire logic arr_ack // Array request done
);
  import fpc_pkg::*;

  fpc_st_t st_q, st_d;
  logic launch;
  logic buf_wr;
  logic buf_clear;
  logic [7:0] buf_data;
  logic buf_loaded;
  logic [15:0] page_base;
  logic range_ok;
  logic last_idx;
  logic fault;

  fpc_key_seq u_key (
    .clock(clock),
    .rst_n(rst_n),
    .ctrl_wr(ctrl_wr),
    .key(ctrl_wdata[`FPC_KEY_MSB:`FPC_KEY_LSB]),
    .instr_done(instr_done),
    .busy(st_q.busy),
    .launch(launch)
  );

  fpc_page_buf #(
    .DEPTH(BUF_DEPTH),
    .IDX_W(IDX_W),
    .DATA_W(8)
  ) u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(buf_wr),
    .wr_idx(xdata_addr[IDX_W-1:0]),
    .wr_data(xdata_wdata),
    .clear(buf_clear),
    .rd_idx(st_q.idx),
    .rd_data(buf_data),
    .rd_loaded(buf_loaded)
  );

  // Buffer is write-only and hidden unless mapped
  assign buf_wr = xdata_wr && st_q.map_sel;
  assign buf_clear = st_q.state == FPC_ST_CLEAR;
  assign page_base = {st_q.page, 7'h00};
  assign last_idx = st_q.idx == IDX_W'(BUF_DEPTH - 1);
  assign fault = brown_out && (st_q.state == FPC_ST_ERASE ||
    st_q.state == FPC_ST_PROG);

  // Targets outside the writable part of a space are refused
  always_comb
  begin
    unique case (st_q.space)
      FPC_SP_CODE: range_ok = 1'b1;
      FPC_SP_SIG: range_ok = page_base <= `FPC_SIG_TOP;
      FPC_SP_FUSE: range_ok = page_base <= `FPC_FUSE_TOP;
      FPC_SP_RSVD: range_ok = 1'b0;
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    st_d.ram_wr = 1'b0;
    st_d.arr_rd = 1'b0;

    // Control register: every write updates mapping and space
    if (ctrl_wr)
    begin
      st_d.map_sel = ctrl_wdata[`FPC_MAP_BIT];
      st_d.space = fpc_space_t'(ctrl_wdata[`FPC_SEL_MSB:`FPC_SEL_LSB]);
    end

    // Data writes: buffer when mapped, data memory otherwise
    if (xdata_wr)
    begin
      if (st_q.map_sel)
      begin
        st_d.page = xdata_addr[`FPC_PAGE_MSB:`FPC_PAGE_LSB];
        st_d.half = xdata_addr[`FPC_HALF_BIT];
      end
      else
      begin
        st_d.ram_wr = 1'b1;
        st_d.ram_ext = ext_ram_select;
        st_d.ram_addr = xdata_addr;
        st_d.ram_wdata = xdata_wdata;
      end
    end

    // Code reads follow the space select; reserved reads nothing
    if (code_rd && st_q.space != FPC_SP_RSVD)
    begin
      st_d.arr_rd = 1'b1;
      st_d.arr_rd_space = st_q.space;
      st_d.arr_rd_addr = code_addr;
    end

    unique case (st_q.state)
      FPC_ST_IDLE:
      begin
        if (launch && range_ok)
        begin
          st_d.tgt_space = st_q.space;
          st_d.tgt_page = st_q.page;
          st_d.tgt_half = st_q.half;
          st_d.internal = exec_internal;
          st_d.idx = '0;
          if (auto_page_erase)
          begin
            st_d.state = FPC_ST_ERASE;
            st_d.arr_req = 1'b1;
            st_d.arr_erase = 1'b1;
            st_d.arr_space = st_q.space;
            st_d.arr_addr = page_base;
          end
          else
            st_d.state = FPC_ST_PROG;
        end
      end
      FPC_ST_ERASE:
      begin
        if (fault)
        begin
          st_d.arr_req = 1'b0;
          st_d.err = 1'b1;
          st_d.state = FPC_ST_CLEAR;
        end
        else if (arr_ack)
        begin
          st_d.arr_req = 1'b0;
          st_d.arr_erase = 1'b0;
          st_d.state = FPC_ST_PROG;
        end
      end
      FPC_ST_PROG:
      begin
        if (fault)
        begin
          st_d.arr_req = 1'b0;
          st_d.err = 1'b1;
          st_d.state = FPC_ST_CLEAR;
        end
        else if (st_q.arr_req)
        begin
          if (arr_ack)
          begin
            st_d.arr_req = 1'b0;
            st_d.idx = st_q.idx + 1'b1;
            if (last_idx)
              st_d.state = FPC_ST_CLEAR;
          end
        end
        else if (buf_loaded)
        begin
          // Only loaded bytes go out; the array keeps the zero bits
          st_d.arr_req = 1'b1;
          st_d.arr_erase = 1'b0;
          st_d.arr_space = st_q.tgt_space;
          st_d.arr_addr = {st_q.tgt_page, st_q.tgt_half, st_q.idx};
          st_d.arr_wdata = buf_data;
        end
        else
        begin
          // Unloaded bytes are skipped: old data or erased FFH stays
          st_d.idx = st_q.idx + 1'b1;
          if (last_idx)
            st_d.state = FPC_ST_CLEAR;
        end
      end
      FPC_ST_CLEAR:
        st_d.state = FPC_ST_IDLE;
    endcase

    // A fault in the same cycle as the clear keeps the flag set
    if (nv_error_clr && !(fault && !st_q.err))
      st_d.err = 1'b0;
    if (fault)
      st_d.err = 1'b1;

    st_d.busy = st_d.state != FPC_ST_IDLE;
    // Launch mode drops with busy so the core hold is a plain flop
    st_d.internal = st_d.internal && st_d.busy;
    st_d.rdata = {4'h0, st_d.map_sel, st_d.space, st_d.busy};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.state <= FPC_ST_IDLE;
    end
    else
      st_q <= st_d;
  end

  assign ctrl_rdata = st_q.rdata;
  assign ram_wr = st_q.ram_wr;
  assign ram_ext = st_q.ram_ext;
  assign ram_addr = st_q.ram_addr;
  assign ram_wdata = st_q.ram_wdata;
  assign arr_rd = st_q.arr_rd;
  assign arr_rd_space = st_q.arr_rd_space;
  assign arr_rd_addr = st_q.arr_rd_addr;
  assign program_in_progress = st_q.busy;
  assign cpu_idle = st_q.internal;
  assign nv_error = st_q.err;
  assign arr_req = st_q.arr_req;
  assign arr_erase = st_q.arr_erase;
  assign arr_space = st_q.arr_space;
  assign arr_addr = st_q.arr_addr;
  assign arr_wdata = st_q.arr_wdata;

  sequence s_go;
    st_q.state == FPC_ST_IDLE && launch && range_ok;
  endsequence
  sequence s_fault;
    fault && !nv_error_clr;
  endsequence
  sequence s_issue;
    st_q.state == FPC_ST_PROG && !st_q.arr_req && buf_loaded && !fault;
  endsequence

  a_ram_steer: assert property (@(posedge clock) disable iff (!rst_n)
    xdata_wr && !st_q.map_sel |=> ram_wr && ram_addr == $past(xdata_addr))
    else $error("unmapped write missed data memory");
  a_map_override: assert property (@(posedge clock) disable iff (!rst_n)
    xdata_wr && st_q.map_sel |=> !ram_wr)
    else $error("mapped write reached data memory");
  a_busy_launch: assert property (@(posedge clock) disable iff (!rst_n)
    s_go |=> program_in_progress && ctrl_rdata[`FPC_BUSY_BIT])
    else $error("busy not set on launch");
  a_erase_first: assert property (@(posedge clock) disable iff (!rst_n)
    s_go ##0 auto_page_erase |=> arr_req && arr_erase &&
    arr_addr[6:0] == 7'h00) else $error("auto-erase not issued first");
  a_brownout_err: assert property (@(posedge clock) disable iff (!rst_n)
    s_fault |=> nv_error && !arr_req ##1 !program_in_progress)
    else $error("brown-out not flagged");
  a_ro_guard: assert property (@(posedge clock) disable iff (!rst_n)
    arr_req && arr_space == FPC_SP_FUSE |-> arr_addr <= `FPC_FUSE_TOP)
    else $error("security range targeted");
  a_rsvd_read: assert property (@(posedge clock) disable iff (!rst_n)
    code_rd && st_q.space == FPC_SP_RSVD |=> !arr_rd)
    else $error("reserved space read");
  a_idle_cpu: assert property (@(posedge clock) disable iff (!rst_n)
    s_go ##0 exec_internal |=> cpu_idle)
    else $error("core not idled");
  a_skip_unloaded: assert property (@(posedge clock) disable iff (!rst_n)
    st_q.state == FPC_ST_PROG && !arr_req && !buf_loaded && !fault |=>
    !arr_req) else $error("unloaded byte programmed");
  // Each loaded byte goes to the latched page and half
  a_target_page: assert property (@(posedge clock) disable iff (!rst_n)
    s_issue |=> arr_req && !arr_erase && arr_wdata == $past(buf_data) &&
    arr_addr == {$past(st_q.tgt_page), $past(st_q.tgt_half), $past(st_q.idx)})
    else $error("program request off target");
  a_code_read: assert property (@(posedge clock) disable iff (!rst_n)
    code_rd && st_q.space != FPC_SP_RSVD |=> arr_rd &&
    arr_rd_space == $past(st_q.space) && arr_rd_addr == $past(code_addr))
    else $error("code read not mapped");
  a_sig_guard: assert property (@(posedge clock) disable iff (!rst_n)
    arr_req && arr_space == FPC_SP_SIG |-> arr_addr <= `FPC_SIG_TOP)
    else $error("signature range targeted");
  a_rsvd_launch: assert property (@(posedge clock) disable iff (!rst_n)
    st_q.state == FPC_ST_IDLE && st_q.space == FPC_SP_RSVD |=>
    !arr_req && st_q.state == FPC_ST_IDLE)
    else $error("reserved space launched");
  a_ext_select: assert property (@(posedge clock) disable iff (!rst_n)
    xdata_wr && !st_q.map_sel |=> ram_ext == $past(ext_ram_select))
    else $error("external select not followed");
  a_busy_drop: assert property (@(posedge clock) disable iff (!rst_n)
    st_q.state == FPC_ST_CLEAR |=> !program_in_progress)
    else $error("busy not cleared");
  a_err_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    nv_error && !nv_error_clr |=> nv_error)
    else $error("error flag lost");
endmodule // fpc_flash_ctrl
`default_nettype wire

// ==== core/fpc_key_seq.sv ====
/*
  Launch-key detector: arms on the first key, fires on the second.
  Assumes instr_done pulses once per retired instruction.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpc_consts.svh"
module fpc_key_seq (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Synchronous reset
  input wire logic ctrl_wr, // Control register write
  input wire logic [3:0] key, // Launch-key field
  input wire logic instr_done, // Instruction retired
  input wire logic busy, // Programming in progress
  output logic launch // One-cycle launch
);
  import fpc_pkg::*;
  fpc_key_st_t st_q, st_d;
  always_comb
  begin
    st_d = st_q;
    st_d.launch = 1'b0;
    if (ctrl_wr && key == `FPC_KEY_ARM)
      st_d.armed = 1'b1;
    else if (ctrl_wr && key == `FPC_KEY_FIRE && st_q.armed)
    begin
      st_d.armed = 1'b0;
      st_d.launch = !busy;
    end
    else if (ctrl_wr || instr_done)
      st_d.armed = 1'b0;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign launch = st_q.launch;
  sequence s_arm;
    ctrl_wr && key == `FPC_KEY_ARM;
  endsequence
  sequence s_fire;
    ctrl_wr && key == `FPC_KEY_FIRE && !busy;
  endsequence
  a_launch_pair: assert property (@(posedge clock) disable iff (!rst_n)
    s_arm ##1 s_fire |=> launch) else $error("key pair not launched");
  a_launch_cause: assert property (@(posedge clock) disable iff (!rst_n)
    launch |-> $past(ctrl_wr) && $past(key) == `FPC_KEY_FIRE)
    else $error("launch without second key");
endmodule // fpc_key_seq
`default_nettype wire

// ==== core/fpc_page_buf.sv ====
/*
  Half-page buffer with per-byte loaded markers, write once.
  Assumes clear is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module fpc_page_buf #(
  parameter int DEPTH = 64,
  parameter int IDX_W = 6,
  parameter int DATA_W = 8
) (
  input wire logic clock, // Core clock
  input wire logic rst_n, // Synchronous reset
  input wire logic wr_en, // Byte load
  input wire logic [IDX_W-1:0] wr_idx, // Load offset
  input wire logic [DATA_W-1:0] wr_data, // Load data
  input wire logic clear, // Drop all contents
  input wire logic [IDX_W-1:0] rd_idx, // Read offset
  output logic [DATA_W-1:0] rd_data, // Read data
  output logic rd_loaded // Read entry loaded
);
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] data;
    logic [DEPTH-1:0] loaded;
  } fpc_buf_st_t;
  fpc_buf_st_t st_q, st_d;
  logic [DEPTH-1:0][DATA_W-1:0] data_nx;
  logic [DEPTH-1:0] loaded_nx;
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_entry
      logic hit;
      assign hit = wr_en && wr_idx == IDX_W'(gi) && !st_q.loaded[gi];
      assign loaded_nx[gi] = !clear && (st_q.loaded[gi] || hit);
      assign data_nx[gi] = clear ? '1 : hit ? wr_data : st_q.data[gi];
    end
  endgenerate
  always_comb
  begin
    st_d.data = data_nx;
    st_d.loaded = loaded_nx;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      st_q <= '1 ^ {{(DEPTH*DATA_W){1'b0}}, {DEPTH{1'b1}}};
    else
      st_q <= st_d;
  end
  assign rd_data = st_q.data[rd_idx];
  assign rd_loaded = st_q.loaded[rd_idx];
  a_write_once: assert property (@(posedge clock) disable iff (!rst_n)
    wr_en && !clear && st_q.loaded[wr_idx] |=>
    st_q.data[$past(wr_idx)] == $past(st_q.data[wr_idx]))
    else $error("loaded byte overwritten");
  a_clear_all: assert property (@(posedge clock) disable iff (!rst_n)
    clear |=> st_q.loaded == '0) else $error("buffer not cleared");
endmodule // fpc_page_buf
`default_nettype wire

// ==== core/fpc_pkg.sv ====
/*
  Types of the flash page program controller.
  Assumes fpc_consts.svh is on the include path.
*/
package fpc_pkg;
  typedef enum logic [1:0] {
    FPC_SP_CODE = 2'h0,
    FPC_SP_SIG = 2'h1,
    FPC_SP_FUSE = 2'h2,
    FPC_SP_RSVD = 2'h3
  } fpc_space_t;
  typedef enum logic [3:0] {
    FPC_ST_IDLE = 4'h1,
    FPC_ST_ERASE = 4'h2,
    FPC_ST_PROG = 4'h4,
    FPC_ST_CLEAR = 4'h8
  } fpc_state_t;
  typedef struct packed {
    logic armed;
    logic launch;
  } fpc_key_st_t;
  typedef struct packed {
    fpc_state_t state;
    logic busy;
    logic map_sel;
    fpc_space_t space;
    fpc_space_t tgt_space;
    logic [8:0] page;
    logic half;
    logic [8:0] tgt_page;
    logic tgt_half;
    logic [5:0] idx;
    logic internal;
    logic err;
    logic [7:0] rdata;
    logic ram_wr;
    logic ram_ext;
    logic [15:0] ram_addr;
    logic [7:0] ram_wdata;
    logic arr_rd;
    fpc_space_t arr_rd_space;
    logic [15:0] arr_rd_addr;
    logic arr_req;
    logic arr_erase;
    fpc_space_t arr_space;
    logic [15:0] arr_addr;
    logic [7:0] arr_wdata;
  } fpc_st_t;
endpackage

// ==== sim/fpc_array_model.sv ====
/*
  Flash array stand-in: answers each request, erases whole pages and
  programs zero bits only.
  Assumes requests hold steady until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module fpc_array_model (
  input wire logic clock, // Core clock
  input wire logic slow, // Long answer delay
  input wire logic arr_req, // Request
  input wire logic arr_erase, // Erase request
  input wire fpc_pkg::fpc_space_t arr_space, // Target space
  input wire logic [15:0] arr_addr, // Target address
  input wire logic [7:0] arr_wdata, // Program data
  output logic arr_ack // Done pulse
);
  import fpc_pkg::*;
  logic [7:0] mem [256];
  logic [4:0] wait_q;
  int prog_cnt;
  int erase_cnt;
  fpc_space_t last_space;
  initial
  begin
    arr_ack = 1'b0;
    wait_q = 5'h00;
    prog_cnt = 0;
    erase_cnt = 0;
    last_space = FPC_SP_RSVD;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'hF3;
  end
  // Ack is a single pulse; the request seen with ack high is not retaken
  always @(posedge clock)
  begin
    arr_ack <= 1'b0;
    if (!arr_req || arr_ack)
      wait_q <= 5'h00;
    else if (wait_q < (slow ? 5'h14 : 5'h00))
      wait_q <= wait_q + 5'h01;
    else
    begin
      arr_ack <= 1'b1;
      last_space <= arr_space;
      if (arr_erase)
      begin
        erase_cnt <= erase_cnt + 1;
        for (int i = 0; i < 128; i++)
          mem[{arr_addr[7], i[6:0]}] <= 8'hFF;
      end
      else
      begin
        prog_cnt <= prog_cnt + 1;
        mem[arr_addr[7:0]] <= mem[arr_addr[7:0]] & arr_wdata;
      end
    end
  end
endmodule // fpc_array_model
`default_nettype wire

// ==== sim/testbench.sv ====
/*
  Self-checking bench of the flash page program controller.
  Assumes fpc_pkg and fpc_array_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpc_pkg::*;
  logic clock, rst_n, instr_done, ctrl_wr, xdata_wr, ext_ram_select;
  logic code_rd, auto_page_erase, exec_internal, brown_out, nv_error_clr;
  logic arr_ack, slow, ram_wr, ram_ext, arr_rd, program_in_progress;
  logic cpu_idle, nv_error, arr_req, arr_erase;
  logic [7:0] ctrl_wdata, ctrl_rdata, xdata_wdata, ram_wdata, arr_wdata;
  logic [15:0] xdata_addr, ram_addr, code_addr, arr_rd_addr, arr_addr;
  fpc_space_t arr_rd_space, arr_space;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  fpc_flash_ctrl #(.BUF_DEPTH(64), .IDX_W(6)) i_dut (.clock(clock),
    .rst_n(rst_n), .instr_done(instr_done), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .xdata_wr(xdata_wr),
    .xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
    .ext_ram_select(ext_ram_select), .ram_wr(ram_wr), .ram_ext(ram_ext),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .code_rd(code_rd),
    .code_addr(code_addr), .arr_rd(arr_rd), .arr_rd_space(arr_rd_space),
    .arr_rd_addr(arr_rd_addr), .auto_page_erase(auto_page_erase),
    .exec_internal(exec_internal), .brown_out(brown_out),
    .nv_error_clr(nv_error_clr), .program_in_progress(program_in_progress),
    .cpu_idle(cpu_idle), .nv_error(nv_error), .arr_req(arr_req),
    .arr_erase(arr_erase), .arr_space(arr_space), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_ack(arr_ack));
  fpc_array_model i_array (.clock(clock), .slow(slow), .arr_req(arr_req),
    .arr_erase(arr_erase), .arr_space(arr_space), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_ack(arr_ack));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic close_out;
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic cmp(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic keys(input logic [7:0] a, input logic [7:0] b);
    @(negedge clock);
    ctrl_wr = 1'b1;
    instr_done = 1'b1;
    ctrl_wdata = a;
    if (a != b)
    begin
      @(negedge clock);
      ctrl_wdata = b;
    end
    @(negedge clock);
    ctrl_wr = 1'b0;
    instr_done = 1'b0;
  endtask
  task automatic ctrl(input logic [7:0] v);
    keys(v, v);
  endtask
  task automatic xwr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    xdata_wr = 1'b1;
    instr_done = 1'b1;
    xdata_addr = a;
    xdata_wdata = d;
    @(negedge clock);
    xdata_wr = 1'b0;
    instr_done = 1'b0;
  endtask
  task automatic load(input logic [15:0] a, input logic [7:0] d);
    ctrl(8'h08);
    xwr(a, d);
    ctrl(8'h00);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (program_in_progress !== 1'b0 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    cmp("busy end", 16'h0000, program_in_progress);
  endtask
  task automatic launch(input logic [7:0] a, input logic [7:0] b);
    keys(a, b);
    cyc(2);
    cmp("busy", 16'h0001, program_in_progress);
    cmp("status bit", 16'h0001, ctrl_rdata[0]);
    cmp("core runs", 16'h0000, cpu_idle);
    wait_idle();
  endtask
  task automatic t_reset;
    cmp("ctrl reset", 16'h0000, ctrl_rdata);
    cmp("req reset", 16'h0000, {arr_req, ram_wr, nv_error, cpu_idle});
  endtask
  task automatic t_data;
    ext_ram_select = 1'b1;
    xwr(16'h1234, 8'h77);
    cmp("ram_wr", 16'h0001, ram_wr);
    cmp("ram_ext", 16'h0001, ram_ext);
    cmp("ram_addr", 16'h1234, ram_addr);
    cmp("ram_wdata", 16'h0077, ram_wdata);
    cmp("no array write", 16'h0000, arr_req);
    ctrl(8'h08);
    cmp("map readback", 16'h0008, ctrl_rdata);
    xwr(16'h0181, 8'h77);
    cmp("mapped ram_wr", 16'h0000, ram_wr);
    ctrl(8'h00);
    ext_ram_select = 1'b0;
  endtask
  task automatic t_read;
    for (int s = 0; s < 4; s++)
    begin
      ctrl({5'h00, s[1:0], 1'b0});
      @(negedge clock);
      code_rd = 1'b1;
      code_addr = 16'h0200 + 16'(s);
      @(negedge clock);
      code_rd = 1'b0;
      cmp("arr_rd", {15'h0000, s != 3}, arr_rd);
      if (s != 3)
      begin
        cmp("rd space", 16'(s), arr_rd_space);
        cmp("rd addr", 16'h0200 + 16'(s), arr_rd_addr);
      end
    end
    ctrl(8'h00);
  endtask
  task automatic t_prog;
    ctrl(8'h08);
    xwr(16'h0202, 8'h00);
    xwr(16'h0181, 8'h00);
    xwr(16'h0185, 8'h5A);
    ctrl(8'h00);
    launch(8'h50, 8'hA0);
    cmp("reloaded byte", 16'h0073, i_array.mem[8'h81]);
    cmp("early page byte", 16'h0000, i_array.mem[8'h82]);
    cmp("loaded byte", 16'h0052, i_array.mem[8'h85]);
    cmp("unloaded byte", 16'h00F3, i_array.mem[8'h83]);
    cmp("old page", 16'h00F3, i_array.mem[8'h02]);
    cmp("code space", 16'(FPC_SP_CODE), i_array.last_space);
    cmp("prog count", 16'h0003, 16'(i_array.prog_cnt));
    keys(8'h50, 8'hA0);
    cyc(2);
    wait_idle();
    cmp("cleared buffer", 16'h0003, 16'(i_array.prog_cnt));
  endtask
  task automatic t_abort;
    ctrl(8'h50);
    @(negedge clock);
    instr_done = 1'b1;
    @(negedge clock);
    instr_done = 1'b0;
    ctrl(8'hA0);
    cyc(3);
    cmp("aborted", 16'h0000, program_in_progress);
    keys(8'h56, 8'hA6);
    cyc(3);
    cmp("reserved", 16'h0000, program_in_progress);
  endtask
  task automatic t_erase;
    auto_page_erase = 1'b1;
    exec_internal = 1'b1;
    load(16'h0043, 8'h5A);
    keys(8'h50, 8'hA0);
    cyc(2);
    cmp("core idle", 16'h0001, cpu_idle);
    wait_idle();
    cmp("core resumes", 16'h0000, cpu_idle);
    cmp("erased load", 16'h005A, i_array.mem[8'h43]);
    cmp("erased blank", 16'h00FF, i_array.mem[8'h44]);
    cmp("other half", 16'h00FF, i_array.mem[8'h03]);
    cmp("erase count", 16'h0001, 16'(i_array.erase_cnt));
    auto_page_erase = 1'b0;
    exec_internal = 1'b0;
  endtask
  task automatic t_space;
    for (int s = 1; s < 3; s++)
    begin
      load(16'h0010, 8'hFF);
      launch({4'h5, 1'b0, s[1:0], 1'b0}, {4'hA, 1'b0, s[1:0], 1'b0});
      cmp("space", 16'(s), i_array.last_space);
    end
  endtask
  task automatic t_brown;
    slow = 1'b1;
    load(16'h0010, 8'h00);
    keys(8'h50, 8'hA0);
    cyc(22);
    brown_out = 1'b1;
    cyc(3);
    brown_out = 1'b0;
    wait_idle();
    cmp("error set", 16'h0001, nv_error);
    @(negedge clock);
    nv_error_clr = 1'b1;
    @(negedge clock);
    nv_error_clr = 1'b0;
    cmp("error clr", 16'h0000, nv_error);
    slow = 1'b0;
  endtask
  task automatic t_guard;
    load(16'h0200, 8'h00);
    keys(8'h52, 8'hA2);
    cyc(3);
    cmp("guarded", 16'h0000, program_in_progress);
  endtask
  initial
  begin
    {rst_n, instr_done, ctrl_wr, xdata_wr, ext_ram_select, code_rd} = 6'h00;
    {auto_page_erase, exec_internal, brown_out, nv_error_clr} = 4'h0;
    {ctrl_wdata, xdata_wdata, xdata_addr, code_addr} = 48'h0;
    slow = 1'b0;
    cyc(9);
    rst_n = 1'b1;
    t_reset();
    t_data();
    t_read();
    t_prog();
    t_abort();
    t_erase();
    t_space();
    t_brown();
    t_guard();
    close_out();
  end
endmodule // testbench
`default_nettype wire
